// ==== tmc_pkg.sv ====
// Shared constants for transceiver mode and tuning control
package tmc_pkg;
	// Mode codes
	localparam logic [2:0] TMC_MODE_SLEEP   = 3'h0;
	localparam logic [2:0] TMC_MODE_STANDBY = 3'h1;
	localparam logic [2:0] TMC_MODE_RX_BB   = 3'h2;
	localparam logic [2:0] TMC_MODE_RX_FS   = 3'h3;
	localparam logic [2:0] TMC_MODE_RX      = 3'h4;
	localparam logic [2:0] TMC_MODE_TX_FS   = 3'h6;
	localparam logic [2:0] TMC_MODE_TX      = 3'h7;
	localparam logic [2:0] TMC_MODE_RST     = TMC_MODE_STANDBY;
	// Device byte addresses
	localparam logic [4:0] TMC_ADDR_MATCH_CFG = 5'h06;
	localparam logic [4:0] TMC_ADDR_PAT0      = 5'h08;
	localparam logic [4:0] TMC_ADDR_PAT1      = 5'h09;
	localparam logic [4:0] TMC_ADDR_PAT2      = 5'h0a;
	localparam logic [4:0] TMC_ADDR_PAT3      = 5'h0b;
	localparam logic [4:0] TMC_ADDR_ALT_BW    = 5'h13;
	localparam logic [4:0] TMC_ADDR_HPF       = 5'h16;
	localparam logic [7:0] TMC_BYTE_RST       = 8'h00;
	// Field positions
	localparam int TMC_MATCH_EN_BIT  = 7;
	localparam int TMC_MATCH_LEN_LSB = 5;
	localparam int TMC_MATCH_TOL_LSB = 3;
	localparam int TMC_ALT_BW_BIT    = 2;
	localparam int TMC_HPF_LSB       = 3;
	// Bandwidth in 100 Hz units, HPF cutoff in Hz
	localparam logic [11:0] TMC_BW_STD [4] = '{12'd100, 12'd200, 12'd400, 12'd2000};
	localparam logic [11:0] TMC_BW_ALT [3] = '{12'd143, 12'd285, 12'd667};
	localparam logic [13:0] TMC_HPF_HZ [8] = '{14'd660, 14'd1480, 14'd1750, 14'd1960,
	                                          14'd2550, 14'd3340, 14'd5110, 14'd10200};
	// Strobe timing
	localparam int TMC_CLK_MHZ      = 50;
	localparam int TMC_STROBE_NS    = 2000;
	localparam int TMC_SETUP_NS     = 200;
	localparam int TMC_STROBE_CYC   = (TMC_STROBE_NS * TMC_CLK_MHZ + 999) / 1000;
	localparam int TMC_SETUP_CYC    = (TMC_SETUP_NS * TMC_CLK_MHZ + 999) / 1000;
	localparam int TMC_RD_WAIT_CYC  = 2;
	// Host register offsets and fields
	localparam logic [7:0] TMC_HOST_CTRL   = 8'h00;
	localparam logic [7:0] TMC_HOST_STATUS = 8'h04;
	localparam logic [7:0] TMC_HOST_REGACC = 8'h08;
	localparam int TMC_CTRL_GO_BIT    = 8;
	localparam int TMC_REGACC_WR_BIT  = 16;
	localparam int TMC_REGACC_ADR_LSB = 8;
	localparam logic [1:0] TMC_HTRANS_NONSEQ = 2'h2;
endpackage : tmc_pkg

// ==== tmc_if.sv ====
// Link between the controller and the transceiver control logic
`timescale 1ns/1ps
interface tmc_if;
	logic [2:0] mode;
	logic       mode_en_n;
	logic       reg_we;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       match_n;
	modport dev  (input mode, mode_en_n, reg_we, reg_addr, reg_wdata, output reg_rdata, match_n);
	modport host (output mode, mode_en_n, reg_we, reg_addr, reg_wdata, input reg_rdata, match_n);
endinterface : tmc_if

// ==== tmc_dev.sv ====
// Transceiver mode decode, supplementary tuning and pattern matcher
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module tmc_dev
	import tmc_pkg::*;
#(
	parameter logic [11:0] ALT_BW3_100HZ = 12'd2000
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	tmc_if.dev               LINK,
	input  wire logic        WAKEUP_BOOST_SEL,
	input  wire logic        BIT_SYNC_CLOCK,
	input  wire logic        RX_BIT,
	output logic [2:0]       MODE_APPLIED,
	output logic             XOSC_EN,
	output logic             SYNTH_EN,
	output logic             BASEBAND_EN,
	output logic             RX_EN,
	output logic             TX_EN,
	output logic             WAKE_STEPPED,
	output logic [11:0]      BW_100HZ,
	output logic [13:0]      HPF_HZ
);

	logic        en_n_prev_r;
	logic [2:0]  mode_r;
	logic [7:0]  match_cfg_r;
	logic [7:0]  pat_r [4];
	logic [7:0]  alt_bw_r;
	logic [7:0]  hpf_r;
	logic [7:0]  rdata_r;
	logic        bclk_prev_r;
	logic [31:0] shift_r;
	logic        match_n_r;

	////////////////////////////////////////////////////////////////////////////
	// Mode capture
	wire strobe_rise = !en_n_prev_r && LINK.mode_en_n;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			en_n_prev_r <= 1'b1;
			mode_r      <= TMC_MODE_RST;
		end else begin
			en_n_prev_r <= LINK.mode_en_n;
			if (strobe_rise) begin
				mode_r <= LINK.mode;
			end
		end
	end

	wire xosc_nxt  = (mode_r != TMC_MODE_SLEEP);
	wire synth_nxt = (mode_r == TMC_MODE_RX_FS) || (mode_r == TMC_MODE_RX) ||
	                 (mode_r == TMC_MODE_TX_FS) || (mode_r == TMC_MODE_TX);
	wire bb_nxt    = (mode_r == TMC_MODE_RX_BB) || (mode_r == TMC_MODE_RX_FS) || (mode_r == TMC_MODE_RX);
	wire rx_nxt    = (mode_r == TMC_MODE_RX);
	wire tx_nxt    = (mode_r == TMC_MODE_TX);

	////////////////////////////////////////////////////////////////////////////
	// Register bank
	wire [1:0] bw_code  = 2'h0;
	wire       pat_sel  = (LINK.reg_addr[4:2] == TMC_ADDR_PAT0[4:2]);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			match_cfg_r <= TMC_BYTE_RST;
			alt_bw_r    <= TMC_BYTE_RST;
			hpf_r       <= TMC_BYTE_RST;
			for (int i = 0; i < 4; i++) begin
				pat_r[i] <= TMC_BYTE_RST;
			end
		end else if (LINK.reg_we) begin
			if (LINK.reg_addr == TMC_ADDR_MATCH_CFG) begin
				match_cfg_r <= LINK.reg_wdata;
			end
			if (LINK.reg_addr == TMC_ADDR_ALT_BW) begin
				alt_bw_r <= LINK.reg_wdata;
			end
			if (LINK.reg_addr == TMC_ADDR_HPF) begin
				hpf_r <= LINK.reg_wdata;
			end
			if (pat_sel) begin
				pat_r[LINK.reg_addr[1:0]] <= LINK.reg_wdata;
			end
		end
	end

	wire [7:0] rdata_nxt = (LINK.reg_addr == TMC_ADDR_MATCH_CFG) ? match_cfg_r :
	                       (LINK.reg_addr == TMC_ADDR_ALT_BW)    ? alt_bw_r :
	                       (LINK.reg_addr == TMC_ADDR_HPF)       ? hpf_r :
	                       pat_sel                               ? pat_r[LINK.reg_addr[1:0]] : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Tuning decode
	wire        alt_map  = alt_bw_r[TMC_ALT_BW_BIT];
	wire [1:0]  bw_sel   = match_cfg_r[1:0] & bw_code;
	wire [11:0] bw_nxt   = !alt_map ? TMC_BW_STD[bw_sel] :
	                       (bw_sel == 2'h3) ? ALT_BW3_100HZ : TMC_BW_ALT[bw_sel];
	wire [13:0] hpf_nxt  = TMC_HPF_HZ[hpf_r[TMC_HPF_LSB +: 3]];

	////////////////////////////////////////////////////////////////////////////
	// Pattern matcher
	function automatic logic [5:0] tmc_ones(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h0;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h0, v[i]};
		end
		return n;
	endfunction : tmc_ones

	wire [1:0]  len_code = match_cfg_r[TMC_MATCH_LEN_LSB +: 2];
	wire [1:0]  tol_code = match_cfg_r[TMC_MATCH_TOL_LSB +: 2];
	wire [31:0] pat_word = {pat_r[0], pat_r[1], pat_r[2], pat_r[3]};
	wire [31:0] pat_ref  = pat_word >> {3'h3 - {1'b0, len_code}, 3'h0};
	wire [31:0] cmp_mask = 32'hffffffff >> {3'h3 - {1'b0, len_code}, 3'h0};
	wire [31:0] shift_nx = {shift_r[30:0], RX_BIT};
	wire [5:0]  err_cnt  = tmc_ones((shift_nx ^ pat_ref) & cmp_mask);
	wire        bclk_rise = !bclk_prev_r && BIT_SYNC_CLOCK;
	wire        hit      = match_cfg_r[TMC_MATCH_EN_BIT] && (err_cnt <= {4'h0, tol_code});

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bclk_prev_r <= 1'b0;
			shift_r     <= 32'h0;
			match_n_r   <= 1'b1;
		end else begin
			bclk_prev_r <= BIT_SYNC_CLOCK;
			if (bclk_rise) begin
				shift_r   <= shift_nx;
				match_n_r <= !hit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r      <= 8'h00;
			MODE_APPLIED <= TMC_MODE_RST;
			XOSC_EN      <= 1'b1;
			SYNTH_EN     <= 1'b0;
			BASEBAND_EN  <= 1'b0;
			RX_EN        <= 1'b0;
			TX_EN        <= 1'b0;
			WAKE_STEPPED <= 1'b1;
			BW_100HZ     <= 12'h0;
			HPF_HZ       <= 14'h0;
		end else begin
			rdata_r      <= rdata_nxt;
			MODE_APPLIED <= mode_r;
			XOSC_EN      <= xosc_nxt;
			SYNTH_EN     <= synth_nxt;
			BASEBAND_EN  <= bb_nxt;
			RX_EN        <= rx_nxt;
			TX_EN        <= tx_nxt;
			WAKE_STEPPED <= !WAKEUP_BOOST_SEL;
			BW_100HZ     <= bw_nxt;
			HPF_HZ       <= hpf_nxt;
		end
	end

	assign LINK.reg_rdata = rdata_r;
	assign LINK.match_n   = match_n_r;

endmodule : tmc_dev

// ==== tmc_host.sv ====
// Controller end: AHB-Lite slave driving mode strobe and register link
`timescale 1ns/1ps
module tmc_host
	import tmc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	tmc_if.host              LINK,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic [31:0]      HRDATA
);

	typedef enum logic [2:0] {S_IDLE, S_LEAD, S_LOW, S_TAIL, S_RD} tmc_state_t;

	tmc_state_t state_r;
	logic [7:0] cnt_r;
	logic [2:0] mode_req_r;
	logic [7:0] rd_byte_r;
	logic       wr_pend_r;
	logic [7:0] wr_addr_r;
	logic       acc_r;

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave
	wire take      = HSEL && HREADY && HTRANS[1];
	wire busy      = (state_r != S_IDLE);
	wire do_ctrl   = wr_pend_r && (wr_addr_r == TMC_HOST_CTRL) && !busy && HWDATA[TMC_CTRL_GO_BIT];
	wire do_acc    = wr_pend_r && (wr_addr_r == TMC_HOST_REGACC) && !busy && !do_ctrl;
	wire acc_wr    = HWDATA[TMC_REGACC_WR_BIT];
	wire [31:0] rd_nxt = (HADDR[7:0] == TMC_HOST_CTRL)   ? {29'h0, mode_req_r} :
	                     (HADDR[7:0] == TMC_HOST_STATUS) ? {27'h0, mode_req_r, !LINK.match_n, busy} :
	                     (HADDR[7:0] == TMC_HOST_REGACC) ? {24'h0, rd_byte_r} : 32'h0;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
			HRDATA    <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			wr_pend_r <= take && HWRITE;
			if (take) begin
				wr_addr_r <= HADDR[7:0];
			end
			if (take && !HWRITE) begin
				HRDATA <= rd_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobe and register access sequencer
	wire cnt_done = (cnt_r == 8'h0);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r         <= S_IDLE;
			cnt_r           <= 8'h0;
			mode_req_r      <= TMC_MODE_RST;
			rd_byte_r       <= 8'h0;
			acc_r           <= 1'b0;
			LINK.mode       <= TMC_MODE_RST;
			LINK.mode_en_n  <= 1'b1;
			LINK.reg_we     <= 1'b0;
			LINK.reg_addr   <= 5'h0;
			LINK.reg_wdata  <= 8'h0;
		end else begin
			LINK.reg_we <= 1'b0;
			if (!cnt_done) begin
				cnt_r <= cnt_r - 8'h1;
			end
			unique case (state_r)
				S_IDLE: begin
					if (do_ctrl) begin
						mode_req_r     <= HWDATA[2:0];
						LINK.mode_en_n <= 1'b0;
						cnt_r          <= 8'(TMC_SETUP_CYC - 1);
						state_r        <= S_LEAD;
					end else if (do_acc) begin
						LINK.reg_addr  <= HWDATA[TMC_REGACC_ADR_LSB +: 5];
						LINK.reg_wdata <= HWDATA[7:0];
						LINK.reg_we    <= acc_wr;
						acc_r          <= acc_wr;
						cnt_r          <= 8'(TMC_RD_WAIT_CYC);
						state_r        <= S_RD;
					end
				end
				S_LEAD: begin
					if (cnt_done) begin
						LINK.mode <= mode_req_r;
						cnt_r     <= 8'(TMC_STROBE_CYC - TMC_SETUP_CYC - 1);
						state_r   <= S_LOW;
					end
				end
				S_LOW: begin
					if (cnt_done) begin
						LINK.mode_en_n <= 1'b1;
						cnt_r          <= 8'(TMC_SETUP_CYC - 1);
						state_r        <= S_TAIL;
					end
				end
				S_TAIL: begin
					if (cnt_done) begin
						state_r <= S_IDLE;
					end
				end
				S_RD: begin
					if (cnt_done) begin
						if (!acc_r) begin
							rd_byte_r <= LINK.reg_rdata;
						end
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

endmodule : tmc_host

// ==== tmc_chk.sv ====
// Assertions on the link between the controller end and the transceiver end
`timescale 1ns/1ps
module tmc_chk
	import tmc_pkg::*;
(
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic [2:0] mode,
	input wire logic       mode_en_n,
	input wire logic       reg_we,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       match_n
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [7:0] low_cnt_r;
	logic       unmap_r;
	wire        pat_sel = reg_addr[4:2] == 3'h2;
	wire        mapped  = pat_sel || reg_addr == TMC_ADDR_MATCH_CFG || reg_addr == TMC_ADDR_ALT_BW ||
	                      reg_addr == TMC_ADDR_HPF;
	// Strobe low time in cycles, saturating
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			low_cnt_r <= 8'h00;
			unmap_r   <= 1'b1;
		end else begin
			low_cnt_r <= mode_en_n ? 8'h00 : low_cnt_r + {7'h0, low_cnt_r != 8'hff};
			unmap_r   <= !mapped;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_mode_quiet_high: assert property (mode_en_n && $past(mode_en_n) |-> $stable(mode))
		else $error("mode code moved while strobe high");
	a_strobe_width: assert property ($rose(mode_en_n) |-> low_cnt_r >= 8'(TMC_STROBE_CYC))
		else $error("strobe low pulse too short");
	a_mode_setup: assert property ($rose(mode_en_n) |-> $past(mode, 10) == mode)
		else $error("mode code not set up before strobe rise");
	a_mode_hold: assert property ($rose(mode_en_n) |-> $stable(mode)[*8])
		else $error("mode code not held after strobe rise");
	a_strobe_gap: assert property ($rose(mode_en_n) |=> mode_en_n[*8])
		else $error("strobe fell again too soon");
	a_we_single: assert property (reg_we |=> !reg_we)
		else $error("register write pulse longer than one cycle");
	a_unmapped_zero: assert property (unmap_r |-> reg_rdata == 8'h00)
		else $error("unmapped device byte read nonzero");
	a_pattern_kept: assert property ((reg_we && pat_sel) ##1 (!reg_we && $stable(reg_addr))
		##1 (!reg_we && $stable(reg_addr)) |=> reg_rdata == $past(reg_wdata, 3))
		else $error("pattern byte not stored");
	c_strobe: cover property ($rose(mode_en_n));
	c_match: cover property ($fell(match_n));
	c_pat_write: cover property (reg_we && pat_sel);
endmodule : tmc_chk

// ==== tb_tmc.sv ====
// Self-checking bench joining the controller end and the transceiver end
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_tmc
	import tmc_pkg::*;
;
	logic        clk, rst_n, hwrite, hready, hresp, boost, bclk, rx_bit, wake, xo, sy, bb, rx, tx;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, q, pat;
	logic [2:0]  mode_applied, prev;
	logic [11:0] bw;
	logic [13:0] hpf;
	logic [7:0]  b;
	int          n_errors, checked, cycles;
	logic [2:0]  m_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	logic [4:0]  e_tab [7] = '{5'h00, 5'h10, 5'h14, 5'h1c, 5'h1a, 5'h18, 5'h19};
	logic [4:0]  k_tab [7] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1b, 5'h1f, 5'h1b};
	wire  [4:0]  en = {xo, sy, bb, rx, tx};
	tmc_if tmc_if_i();
	tmc_host tmc_host_i(.CLK(clk), .RST_N(rst_n), .LINK(tmc_if_i), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata));
	tmc_dev tmc_dev_i(.CLK(clk), .RST_N(rst_n), .LINK(tmc_if_i), .WAKEUP_BOOST_SEL(boost), .BIT_SYNC_CLOCK(bclk),
		.RX_BIT(rx_bit), .MODE_APPLIED(mode_applied), .XOSC_EN(xo), .SYNTH_EN(sy), .BASEBAND_EN(bb), .RX_EN(rx),
		.TX_EN(tx), .WAKE_STEPPED(wake), .BW_100HZ(bw), .HPF_HZ(hpf));
	tmc_chk tmc_chk_i(.CLK(clk), .RST_N(rst_n), .mode(tmc_if_i.mode), .mode_en_n(tmc_if_i.mode_en_n),
		.reg_we(tmc_if_i.reg_we), .reg_addr(tmc_if_i.reg_addr), .reg_wdata(tmc_if_i.reg_wdata),
		.reg_rdata(tmc_if_i.reg_rdata), .match_n(tmc_if_i.match_n));
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		htrans <= TMC_HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic wait_idle;
		logic [31:0] s;
		s = 32'h1;
		while (s[0] === 1'b1) ahb(1'b0, TMC_HOST_STATUS, 32'h0, s);
	endtask : wait_idle
	task automatic dev_wr(input logic [4:0] a, input logic [7:0] d);
		ahb(1'b1, TMC_HOST_REGACC, {15'h0, 1'b1, 3'h0, a, d}, q);
		wait_idle();
		repeat (2) @(posedge clk);
	endtask : dev_wr
	task automatic dev_rd(input logic [4:0] a, output logic [7:0] d);
		ahb(1'b1, TMC_HOST_REGACC, {15'h0, 1'b0, 3'h0, a, 8'h00}, q);
		wait_idle();
		ahb(1'b0, TMC_HOST_REGACC, 32'h0, q);
		d = q[7:0];
	endtask : dev_rd
	// Bits go out oldest first, one bit clock each
	task automatic send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_bit <= v[i];
			@(posedge clk);
			bclk <= 1'b1;
			repeat (2) @(posedge clk);
			bclk <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : send
	task automatic conclude;
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, rst_n, hwrite, boost, bclk, rx_bit} = 6'h0;
		{htrans, haddr, hwdata} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(mode_applied, 3'h1)
		`CHK({wake, bw, hpf}, {1'b1, 12'd100, 14'd660})
		boost <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(wake, 1'b0)
		for (int i = 0; i < 7; i++) begin
			prev = mode_applied;
			ahb(1'b1, TMC_HOST_CTRL, 32'h100 | 32'(m_tab[i]), q);
			repeat (50) @(posedge clk);
			`CHK(mode_applied, prev)
			wait_idle();
			`CHK(mode_applied, m_tab[i])
			`CHK(en & k_tab[i], e_tab[i] & k_tab[i])
		end
		dev_rd(TMC_ADDR_PAT0, b);
		`CHK(b, 8'h00)
		dev_wr(TMC_ADDR_ALT_BW, 8'h04);
		`CHK(bw, 12'd143)
		dev_rd(TMC_ADDR_ALT_BW, b);
		`CHK(b, 8'h04)
		dev_wr(TMC_ADDR_ALT_BW, 8'h00);
		`CHK(bw, 12'd100)
		for (int c = 0; c < 8; c++) begin
			dev_wr(TMC_ADDR_HPF, 8'(c << 3));
			`CHK(hpf, TMC_HPF_HZ[c])
		end
		dev_rd(TMC_ADDR_HPF, b);
		`CHK(b, 8'h38)
		dev_wr(TMC_ADDR_HPF, 8'h00);
		`CHK(hpf, TMC_HPF_HZ[0])
		dev_rd(5'h1f, b);
		`CHK(b, 8'h00)
		ahb(1'b0, 8'h0c, 32'h0, q);
		`CHK(q, 32'h0)
		pat = 32'h93aa55c3;
		for (int j = 0; j < 4; j++) dev_wr(TMC_ADDR_PAT0 + 5'(j), pat[31 - 8 * j -: 8]);
		dev_wr(TMC_ADDR_MATCH_CFG, 8'he0);
		send(pat, 32);
		`CHK(tmc_if_i.match_n, 1'b0)
		ahb(1'b0, TMC_HOST_STATUS, 32'h0, q);
		`CHK({hresp, q[1]}, {1'b0, 1'b1})
		send(32'h1, 1);
		`CHK(tmc_if_i.match_n, 1'b1)
		dev_wr(TMC_ADDR_MATCH_CFG, 8'h80);
		send(32'h93, 8);
		`CHK(tmc_if_i.match_n, 1'b0)
		send(32'h0, 1);
		`CHK(tmc_if_i.match_n, 1'b1)
		dev_wr(TMC_ADDR_MATCH_CFG, 8'ha0);
		send(32'h93aa, 16);
		`CHK(tmc_if_i.match_n, 1'b0)
		dev_wr(TMC_ADDR_MATCH_CFG, 8'hc0);
		send(32'h93aa55, 24);
		`CHK(tmc_if_i.match_n, 1'b0)
		dev_wr(TMC_ADDR_MATCH_CFG, 8'h60);
		send(pat, 32);
		`CHK(tmc_if_i.match_n, 1'b1)
		conclude();
	end
endmodule : tb_tmc
